// ### logic/pea_pkg.sv
// pea_pkg: shared constants, enumerations and helpers for the PDH stimulus
// assumes a 20 MHz system clock and a 1.544 Mbit/s framed line output
`default_nettype none

package pea_pkg;

	// ==================================================================
	// clocking and bit rate
	localparam longint CLK_HZ        = 20_000_000;
	localparam int     CLK_PERIOD_NS = 50;
	localparam longint NOM_BIT_HZ    = 1_544_000;
	localparam longint PPM_DIV       = 1_000_000;
	localparam int     PHASE_W       = 32;
	localparam logic signed [39:0] NCO_NOM_INC =
		40'(NOM_BIT_HZ * (64'd1 << PHASE_W) / CLK_HZ);
	localparam logic signed [39:0] NCO_PPM_STEP_Q8 =
		40'(NOM_BIT_HZ * (64'd1 << PHASE_W) * 256 / CLK_HZ / PPM_DIV);
	localparam int     NCO_FRAC_SHIFT = 8;
	localparam logic signed [15:0] PPM_LIMIT = 16'sh007D;
	localparam int     CLK_DET_NS    = 2000;
	localparam int     CLK_DET_CYC   = CLK_DET_NS / CLK_PERIOD_NS;

	// ==================================================================
	// frame layout
	localparam int         FRAME_BITS      = 193;
	localparam int         CHANNELS        = 24;
	localparam int         CH_BITS         = 8;
	localparam int         MF_FRAMES       = 12;
	localparam logic [11:0] FRAMING_PATTERN = 12'h8DC;
	localparam logic [3:0] MFA_MARK        = 4'h5;
	localparam logic [2:0] RAI_BIT_POS     = 3'h1;
	localparam logic [10:0] PRBS_SEED      = 11'h7FF;
	localparam int         BURST_LEN_W     = 16;

	// ==================================================================
	// error timing
	localparam int FRAMES_PER_SEC = 8000;
	localparam int SEVERE_PERCENT = 30;
	localparam int SEVERE_FRAMES  = FRAMES_PER_SEC * SEVERE_PERCENT / 100;

	// ==================================================================
	// modes
	typedef enum logic [2:0] {
		PEA_ERR_NONE,
		PEA_ERR_MANUAL,
		PEA_ERR_BURST,
		PEA_ERR_ERRORED_SECOND,
		PEA_ERR_SEVERELY_ERRORED_SECOND
	} pea_err_mode_e;

	typedef enum logic [2:0] {
		PEA_BURST_1E3, PEA_BURST_1E4, PEA_BURST_1E5,
		PEA_BURST_1E6, PEA_BURST_1E7
	} pea_burst_rate_e;

	typedef enum logic [1:0] {
		PEA_ALM_NONE, PEA_ALM_AIS, PEA_ALM_LOS, PEA_ALM_RAI
	} pea_alarm_e;

	typedef enum logic [1:0] {
		PEA_DEST_FRAMING, PEA_DEST_MFA, PEA_DEST_PATTERN
	} pea_dest_e;

	typedef enum logic [1:0] {
		PEA_CLK_INTERNAL, PEA_CLK_EXTERNAL, PEA_CLK_RECOVERED
	} pea_clk_src_e;

	// frames between burst starts
	function automatic logic [23:0] burst_period(pea_burst_rate_e r);
		case (r)
			PEA_BURST_1E3: burst_period = 24'h0003E8;
			PEA_BURST_1E4: burst_period = 24'h002710;
			PEA_BURST_1E5: burst_period = 24'h0186A0;
			PEA_BURST_1E6: burst_period = 24'h0F4240;
			default:       burst_period = 24'h989680;
		endcase
	endfunction

	// first bit index of a payload channel
	function automatic logic [7:0] slot_first_bit(logic [4:0] slot);
		slot_first_bit = 8'(1 + slot * CH_BITS);
	endfunction

endpackage : pea_pkg

`default_nettype wire

// ### logic/pea_bit_clock.sv
// pea_bit_clock: transmit bit tick from internal nco, external or recovered
// assumes external and recovered clocks are slow pins sampled by clk
`timescale 1ns/1ps
`default_nettype none

module pea_bit_clock
	import pea_pkg::*;
(
	input  wire  logic               clk,
	input  wire  logic               arst_n,
	input  wire  pea_clk_src_e       clk_src,
	input  wire  logic signed [15:0] ppm_offset,
	input  wire  logic               direct_pdh,
	input  wire  logic               ext_clk_pin,
	input  wire  logic               rec_clk_pin,
	output logic                     bit_tick,
	output logic                     clk_detected
);

	localparam int IDLE_W = $clog2(CLK_DET_CYC + 1);

	// ==================================================================
	// pin synchronisers, index 0 external, 1 recovered
	logic [1:0]        pin_s1;
	logic [1:0]        pin_s2;
	logic [1:0]        pin_s3;
	logic [IDLE_W-1:0] idle [2];
	wire  logic [1:0]  pin_edge = pin_s2 & ~pin_s3;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
			pin_s3 <= 2'h0;
		end else begin
			pin_s1 <= {rec_clk_pin, ext_clk_pin};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// idle time since last edge of each source
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idle[0] <= IDLE_W'(CLK_DET_CYC);
			idle[1] <= IDLE_W'(CLK_DET_CYC);
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pin_edge[i])
					idle[i] <= '0;
				else if (idle[i] != IDLE_W'(CLK_DET_CYC))
					idle[i] <= idle[i] + 1'b1;
			end
		end
	end

	// ==================================================================
	// nco with ppm offset, saturated to the tolerated range
	logic [PHASE_W-1:0] phase;
	wire  logic signed [15:0] ppm_sat =
		(ppm_offset > PPM_LIMIT)  ? PPM_LIMIT :
		(ppm_offset < -PPM_LIMIT) ? -PPM_LIMIT : ppm_offset;
	wire  logic signed [15:0] ppm_eff = direct_pdh ? ppm_sat : 16'sh0000;
	wire  logic signed [39:0] ppm_prod = 40'(ppm_eff) * NCO_PPM_STEP_Q8;
	wire  logic [PHASE_W-1:0] nco_inc =
		PHASE_W'(NCO_NOM_INC + (ppm_prod >>> NCO_FRAC_SHIFT));
	wire  logic [PHASE_W:0]   phase_sum = {1'b0, phase} + {1'b0, nco_inc};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			phase <= '0;
		else
			phase <= phase_sum[PHASE_W-1:0];
	end

	// ==================================================================
	// source select
	wire logic next_tick =
		(clk_src == PEA_CLK_EXTERNAL)  ? pin_edge[0] :
		(clk_src == PEA_CLK_RECOVERED) ? pin_edge[1] :
		phase_sum[PHASE_W];
	wire logic next_det =
		(clk_src == PEA_CLK_EXTERNAL)  ? idle[0] != IDLE_W'(CLK_DET_CYC) :
		(clk_src == PEA_CLK_RECOVERED) ? idle[1] != IDLE_W'(CLK_DET_CYC) :
		1'b1;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_tick     <= 1'b0;
			clk_detected <= 1'b0;
		end else begin
			bit_tick     <= next_tick;
			clk_detected <= next_det;
		end
	end

endmodule // pea_bit_clock

`default_nettype wire

// ### logic/pea_tx_stimulus.sv
// pea_tx_stimulus: 1.544 Mbit/s frame builder with alarm and error insertion
// assumes control ports are steady on clk; line pins are asynchronous
//
// Summary of operation
// - insertion mode none stops both alarms and errors
// - manual trigger injects exactly burst length errors, nothing in between
// - burst mode repeats error bursts once per 1E3 to 1E7 frames
// - errored second mode injects at least one error every second
// - severely errored second mode errors at most thirty percent of frames
// - trigger ignored outside manual mode; only shows insertion status
// - selected alarm is sent continuously outside insertion mode none, until set back to none
// - errors land only in the selected destination field
// - burst length sets errors or errored frames per insertion event
// - bit rate is nominal times one plus ppm offset
// - ppm offset applies only when sent directly without carrier layer
// - transmitter works within plus or minus 125 ppm
// - frame is one framing bit plus 24 eight bit channels
// - channel zero carries multiframe alignment, not payload
// - interface off disables transmitter output entirely
// - drop and insert resends received data with local content added
// - transmit clock is internal, external or recovered
`timescale 1ns/1ps
`default_nettype none

module pea_tx_stimulus
	import pea_pkg::*;
(
	input  wire  logic                   clk,
	input  wire  logic                   arst_n,
	input  wire  logic                   tx_on,
	input  wire  logic                   direct_pdh,
	input  wire  pea_clk_src_e           clk_src,
	input  wire  logic signed [15:0]     ppm_offset,
	input  wire  logic                   ext_clk_pin,
	input  wire  logic                   rec_clk_pin,
	input  wire  logic                   rx_data_pin,
	input  wire  logic                   drop_insert,
	input  wire  logic [4:0]             insert_slot,
	input  wire  pea_err_mode_e          err_mode,
	input  wire  pea_burst_rate_e        burst_rate,
	input  wire  pea_dest_e              err_dest,
	input  wire  logic [BURST_LEN_W-1:0] burst_len,
	input  wire  logic                   insert_trig,
	input  wire  pea_alarm_e             alarm_sel,
	output logic                         tx_data,
	output logic                         tx_bit_strobe,
	output logic                         tx_frame_start,
	output logic                         tx_enable,
	output logic                         insert_status,
	output logic                         clk_detected
);

	// ==================================================================
	// bit clock
	logic bit_tick;

	pea_bit_clock u_bit_clock (
		.clk          (clk),
		.arst_n       (arst_n),
		.clk_src      (clk_src),
		.ppm_offset   (ppm_offset),
		.direct_pdh   (direct_pdh),
		.ext_clk_pin  (ext_clk_pin),
		.rec_clk_pin  (rec_clk_pin),
		.bit_tick     (bit_tick),
		.clk_detected (clk_detected)
	);

	// ==================================================================
	// state
	logic [7:0]             bit_idx;
	logic [3:0]             mf_idx;
	logic [12:0]            sec_frame;
	logic [23:0]            burst_cnt;
	logic [BURST_LEN_W-1:0] burst_left;
	logic [BURST_LEN_W-1:0] man_left;
	logic                   err_frame;
	logic                   trig_q;
	logic                   rx_s1;
	logic                   rx_s2;
	logic [10:0]            prbs;

	// ==================================================================
	// frame position decode
	wire logic       tick      = bit_tick & tx_on;
	wire logic       frame_end = tick && bit_idx == 8'(FRAME_BITS - 1);
	wire logic [7:0] pay_idx   = bit_idx - 8'h01;
	wire logic [4:0] ch        = 5'(pay_idx >> 3);
	wire logic [2:0] ch_pos    = pay_idx[2:0];
	wire logic [4:0] eff_slot  =
		(insert_slot == 5'h00 || insert_slot >= 5'(CHANNELS)) ? 5'h01 :
		insert_slot;
	wire logic       is_fbit   = bit_idx == 8'h00;
	wire logic       is_ch0    = !is_fbit && ch == 5'h00;
	wire logic       is_local  = !is_fbit && !is_ch0 &&
		(!drop_insert || ch == eff_slot);

	// ==================================================================
	// alarm and error selection
	wire pea_alarm_e alarm_act =
		(err_mode == PEA_ERR_NONE) ? PEA_ALM_NONE : alarm_sel;
	wire logic [7:0] err_pos =
		(err_dest == PEA_DEST_FRAMING) ? 8'h00 :
		(err_dest == PEA_DEST_MFA)     ? 8'h01 :
		drop_insert ? slot_first_bit(eff_slot) : 8'h09;
	wire logic       err_hit = err_frame && bit_idx == err_pos;

	// ==================================================================
	// bit content
	wire logic [7:0] mfa_byte = {MFA_MARK, mf_idx};
	wire logic       fbit     = FRAMING_PATTERN[4'(MF_FRAMES - 1) - mf_idx];
	wire logic       raw_bit  =
		is_fbit  ? fbit :
		is_ch0   ? mfa_byte[3'h7 - ch_pos] :
		is_local ? prbs[10] : rx_s2;
	wire logic       line_bit =
		(alarm_act == PEA_ALM_AIS) ? 1'b1 :
		(alarm_act == PEA_ALM_LOS) ? 1'b0 :
		(alarm_act == PEA_ALM_RAI && !is_fbit && ch_pos == RAI_BIT_POS) ?
		1'b0 : raw_bit ^ err_hit;

	// ==================================================================
	// error scheduling, decided at each frame end for the next frame
	wire logic trig_rise  = insert_trig && !trig_q;
	wire logic man_load   = trig_rise && err_mode == PEA_ERR_MANUAL &&
		man_left == '0;
	wire logic [23:0] period = burst_period(burst_rate);
	wire logic [BURST_LEN_W-1:0] burst_avail =
		(burst_cnt == 24'h000000) ? burst_len : burst_left;
	logic next_err;

	always_comb begin
		case (err_mode)
			PEA_ERR_MANUAL: next_err = man_left != '0;
			PEA_ERR_BURST:  next_err = burst_avail != '0;
			PEA_ERR_ERRORED_SECOND:
				next_err = sec_frame == 13'h0000;
			PEA_ERR_SEVERELY_ERRORED_SECOND:
				next_err = sec_frame < 13'(SEVERE_FRAMES);
			default:        next_err = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			err_frame <= 1'b0;
			sec_frame <= '0;
		end else if (!tx_on) begin
			err_frame <= 1'b0;
			sec_frame <= '0;
		end else if (frame_end) begin
			err_frame <= next_err;
			sec_frame <= (sec_frame == 13'(FRAMES_PER_SEC - 1)) ? '0 :
				sec_frame + 13'h0001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			man_left <= '0;
			trig_q   <= 1'b0;
		end else begin
			trig_q <= insert_trig;
			if (err_mode != PEA_ERR_MANUAL)
				man_left <= '0;
			else if (man_load)
				man_left <= burst_len;
			else if (frame_end && man_left != '0)
				man_left <= man_left - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			burst_cnt  <= '0;
			burst_left <= '0;
		end else if (err_mode != PEA_ERR_BURST) begin
			burst_cnt  <= '0;
			burst_left <= '0;
		end else if (frame_end) begin
			burst_cnt  <= (burst_cnt >= period - 24'h000001) ? '0 :
				burst_cnt + 24'h000001;
			burst_left <= (burst_avail != '0) ? burst_avail - 1'b1 : '0;
		end
	end

	// ==================================================================
	// frame counters, pattern and receive path
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_idx <= '0;
			mf_idx  <= '0;
		end else if (!tx_on) begin
			bit_idx <= '0;
			mf_idx  <= '0;
		end else if (frame_end) begin
			bit_idx <= '0;
			mf_idx  <= (mf_idx == 4'(MF_FRAMES - 1)) ? '0 : mf_idx + 4'h1;
		end else if (tick) begin
			bit_idx <= bit_idx + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prbs  <= PRBS_SEED;
			rx_s1 <= 1'b0;
			rx_s2 <= 1'b0;
		end else begin
			rx_s1 <= rx_data_pin;
			rx_s2 <= rx_s1;
			if (tick && is_local)
				prbs <= {prbs[9:0], prbs[10] ^ prbs[8]};
		end
	end

	// ==================================================================
	// line outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_data        <= 1'b0;
			tx_bit_strobe  <= 1'b0;
			tx_frame_start <= 1'b0;
			tx_enable      <= 1'b0;
			insert_status  <= 1'b0;
		end else begin
			tx_bit_strobe  <= tick;
			tx_frame_start <= tick && is_fbit;
			tx_enable      <= tx_on && alarm_act != PEA_ALM_LOS;
			insert_status  <= err_frame;
			if (!tx_on)
				tx_data <= 1'b0;
			else if (tick)
				tx_data <= line_bit;
		end
	end

	// ==================================================================
	// checks
	AST_NONE_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
		frame_end && err_mode == PEA_ERR_NONE |=> !err_frame)
		else $error("error frame scheduled in mode none");

	AST_MANUAL_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
		man_load |=> man_left == $past(burst_len))
		else $error("manual trigger did not load burst length");

	AST_TRIG_IGNORED: assert property (@(posedge clk) disable iff (!arst_n)
		err_mode != PEA_ERR_MANUAL |=> man_left == '0)
		else $error("trigger acted outside manual mode");

	AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!arst_n)
		tick && bit_idx == 8'(FRAME_BITS - 1) |=> bit_idx == 8'h00)
		else $error("frame not 193 bits");

	AST_AIS_ONES: assert property (@(posedge clk) disable iff (!arst_n)
		tick && alarm_act == PEA_ALM_AIS |=> tx_bit_strobe && tx_data)
		else $error("ais bit not one");

	AST_OFF_SILENT: assert property (@(posedge clk) disable iff (!arst_n)
		!tx_on |=> !tx_enable && !tx_bit_strobe && !tx_data)
		else $error("transmitter active while off");

	AST_SECOND_ERR: assert property (@(posedge clk) disable iff (!arst_n)
		frame_end && err_mode == PEA_ERR_ERRORED_SECOND &&
		sec_frame == 13'h0000 |=> err_frame ##1 insert_status)
		else $error("no error at start of second");

	AST_SEVERE_CAP: assert property (@(posedge clk) disable iff (!arst_n)
		frame_end && err_mode == PEA_ERR_SEVERELY_ERRORED_SECOND &&
		sec_frame >= 13'(SEVERE_FRAMES) |=> !err_frame)
		else $error("severe density above limit");

	AST_MFA_BITS: assert property (@(posedge clk) disable iff (!arst_n)
		tick && is_ch0 && !err_hit && alarm_act == PEA_ALM_NONE |=>
		tx_data == $past(mfa_byte[3'h7 - ch_pos]))
		else $error("channel zero not carrying multiframe alignment");

endmodule // pea_tx_stimulus

`default_nettype wire

// ### dv/pea_rx_model.sv
// pea_rx_model: far-side line receiver that collects framed line bits
// assumes tx_data is valid in the cycle where tx_bit_strobe is high
`timescale 1ns/1ps
`default_nettype none

module pea_rx_model
	import pea_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             tx_data,
	input  wire logic             tx_bit_strobe,
	input  wire logic             tx_frame_start,
	input  wire logic             insert_status,
	output logic [0:FRAME_BITS-1] frame,
	output int                    frame_len,
	output int                    n_frames,
	output logic                  frame_err
);
	logic [0:FRAME_BITS-1] buffer;
	int                    idx;
	logic                  err_acc;

	// ==================================================================
	// bit collection, one frame per framing bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			frame     <= '0;
			buffer    <= '0;
			frame_len <= 0;
			n_frames  <= 0;
			frame_err <= 1'b0;
			idx       <= 0;
			err_acc   <= 1'b0;
		end else begin
			// insert_status lags the error decision by one cycle, so it is
			// already valid for the new frame when its framing bit arrives
			if (tx_bit_strobe && !tx_frame_start && insert_status)
				err_acc <= 1'b1;
			if (tx_bit_strobe && tx_frame_start) begin
				frame     <= buffer;
				frame_len <= idx;
				frame_err <= err_acc;
				n_frames  <= n_frames + 1;
				buffer[0] <= tx_data;
				idx       <= 1;
				err_acc   <= insert_status;
			end else if (tx_bit_strobe) begin
				if (idx < FRAME_BITS)
					buffer[idx] <= tx_data;
				idx <= idx + 1;
			end
		end
	end
endmodule // pea_rx_model

`default_nettype wire

// ### dv/pea_tx_stimulus_bench.sv
// pea_tx_stimulus_bench: directed scenarios for the frame and error builder
// assumes pea_rx_model collects frames; 20 MHz clock
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end

module pea_tx_stimulus_bench
	import pea_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, tx_on = 1'b0, direct_pdh = 1'b1;
	pea_clk_src_e clk_src = PEA_CLK_INTERNAL;
	logic signed [15:0] ppm_offset = '0;
	logic ext_clk_pin = 1'b0, rec_clk_pin = 1'b0, rx_data_pin = 1'b0;
	logic drop_insert = 1'b0, insert_trig = 1'b0;
	logic [4:0] insert_slot = 5'h01;
	pea_err_mode_e err_mode = PEA_ERR_NONE;
	pea_burst_rate_e burst_rate = PEA_BURST_1E3;
	pea_dest_e err_dest = PEA_DEST_MFA;
	logic [BURST_LEN_W-1:0] burst_len = 16'h0001;
	pea_alarm_e alarm_sel = PEA_ALM_NONE;
	logic tx_data, tx_bit_strobe, tx_frame_start, tx_enable;
	logic insert_status, clk_detected, frame_err;
	logic [0:FRAME_BITS-1] frame;
	int frame_len, n_frames, n_mismatch = 0, compares = 0;

	always #25 clk = ~clk;

	pea_tx_stimulus u_pea_tx_stimulus (.clk(clk), .arst_n(arst_n),
		.tx_on(tx_on), .direct_pdh(direct_pdh), .clk_src(clk_src),
		.ppm_offset(ppm_offset), .ext_clk_pin(ext_clk_pin),
		.rec_clk_pin(rec_clk_pin), .rx_data_pin(rx_data_pin),
		.drop_insert(drop_insert), .insert_slot(insert_slot),
		.err_mode(err_mode), .burst_rate(burst_rate), .err_dest(err_dest),
		.burst_len(burst_len), .insert_trig(insert_trig),
		.alarm_sel(alarm_sel), .tx_data(tx_data),
		.tx_bit_strobe(tx_bit_strobe), .tx_frame_start(tx_frame_start),
		.tx_enable(tx_enable), .insert_status(insert_status),
		.clk_detected(clk_detected));

	pea_rx_model u_pea_rx_model (.clk(clk), .arst_n(arst_n),
		.tx_data(tx_data), .tx_bit_strobe(tx_bit_strobe),
		.tx_frame_start(tx_frame_start), .insert_status(insert_status),
		.frame(frame), .frame_len(frame_len), .n_frames(n_frames),
		.frame_err(frame_err));

	// ==================================================================
	// shared tasks
	task automatic results();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wait_frames(input int n);
		int start;
		int i;
		start = n_frames;
		for (i = 0; i < n * 4000 && n_frames < start + n; i++)
			@(posedge clk);
		if (n_frames < start + n) begin
			n_mismatch++;
			$display("[FAIL] t=%0t no frame", $time);
			results();
		end
	endtask

	task automatic run_trig(input pea_err_mode_e m, input int len,
			input int expect_n);
		int k;
		int n_err;
		n_err = 0;
		@(posedge clk);
		err_mode <= m;
		burst_len <= 16'(len);
		@(posedge clk);
		insert_trig <= 1'b1;
		@(posedge clk);
		insert_trig <= 1'b0;
		for (k = 0; k < 4; k++) begin
			wait_frames(1);
			`CHK(frame[1], frame_err)
			`CHK(frame[2:4], 3'b101)
			if (frame_err === 1'b1)
				n_err++;
		end
		`CHK(n_err, expect_n)
		$display("trigger run done");
	endtask

	// ==================================================================
	// scenarios
	task automatic t_frame();
		@(posedge clk);
		tx_on <= 1'b1;
		wait_frames(2);
		`CHK(frame_len, FRAME_BITS)
		`CHK(frame[1:4], MFA_MARK)
		`CHK(tx_enable, 1'b1)
		$display("frame test done");
	endtask

	task automatic t_alarm();
		@(posedge clk);
		err_mode <= PEA_ERR_MANUAL;
		alarm_sel <= PEA_ALM_AIS;
		wait_frames(2);
		`CHK(frame, {FRAME_BITS{1'b1}})
		err_mode <= PEA_ERR_NONE;
		wait_frames(2);
		`CHK(frame[1:4], MFA_MARK)
		err_mode <= PEA_ERR_MANUAL;
		alarm_sel <= PEA_ALM_LOS;
		repeat (3) @(posedge clk);
		`CHK(tx_enable, 1'b0)
		alarm_sel <= PEA_ALM_NONE;
		repeat (3) @(posedge clk);
		`CHK(tx_enable, 1'b1)
		$display("alarm test done");
	endtask

	task automatic t_off();
		int n_stb;
		n_stb = 0;
		@(posedge clk);
		tx_on <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(tx_enable, 1'b0)
		repeat (100) begin
			@(posedge clk);
			if (tx_bit_strobe === 1'b1)
				n_stb++;
		end
		`CHK(n_stb, 0)
		tx_on <= 1'b1;
		$display("off test done");
	endtask

	task automatic t_drop();
		@(posedge clk);
		err_mode <= PEA_ERR_NONE;
		drop_insert <= 1'b1;
		rx_data_pin <= 1'b1;
		wait_frames(2);
		`CHK(frame[17:FRAME_BITS-1], {(FRAME_BITS-17){1'b1}})
		drop_insert <= 1'b0;
		rx_data_pin <= 1'b0;
		$display("drop test done");
	endtask

	task automatic t_clk(input pea_clk_src_e s);
		int n_stb;
		n_stb = 0;
		@(posedge clk);
		clk_src <= s;
		repeat (60) @(posedge clk);
		`CHK(clk_detected, 1'b0)
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			if (i % 7 == 0 && s == PEA_CLK_EXTERNAL)
				ext_clk_pin <= ~ext_clk_pin;
			if (i % 7 == 0 && s == PEA_CLK_RECOVERED)
				rec_clk_pin <= ~rec_clk_pin;
			if (tx_bit_strobe === 1'b1)
				n_stb++;
		end
		`CHK(clk_detected, 1'b1)
		`CHK(n_stb > 5, 1'b1)
		clk_src <= PEA_CLK_INTERNAL;
		repeat (3) @(posedge clk);
		`CHK(clk_detected, 1'b1)
		$display("clock test done");
	endtask

	// ==================================================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_frame();
		run_trig(PEA_ERR_MANUAL, 1, 1);
		run_trig(PEA_ERR_MANUAL, 2, 2);
		run_trig(PEA_ERR_BURST, 2, 2);
		run_trig(PEA_ERR_NONE, 2, 0);
		run_trig(PEA_ERR_SEVERELY_ERRORED_SECOND, 1, 3);
		t_alarm();
		t_drop();
		t_off();
		t_clk(PEA_CLK_EXTERNAL);
		t_clk(PEA_CLK_RECOVERED);
		results();
	end
endmodule // pea_tx_stimulus_bench

`default_nettype wire
